/* File: verilog/aps_pin_gate.sv */
// ata control pin startup state, bus-detect gating and presence input handling
//
// Local design decisions: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

module aps_pin_gate #(
    parameter int STARTUP_CYCLES = aps_pkg::STARTUP_CYCLES
) (
    input  wire logic              clk,
    input  wire logic              nrst,
    input  wire logic [7:0]        reg_addr,
    input  wire logic [31:0]       reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output var  logic [31:0]       reg_rdata,
    input  wire aps_pkg::aps_pins_t core_pins,
    output var  aps_pkg::aps_pins_t pin_o,
    output var  aps_pkg::aps_pins_t pin_oe,
    input  wire logic              bus_detect_gate_in,
    input  wire logic              drive_present_in,
    output var  logic              drive_present_out,
    output var  logic [7:0]        report_byte0,
    output var  logic              startup_done
);

    // state of the block, apart from the startup timer, in one record
    typedef struct packed {
        aps_pkg::aps_state_t st;
        logic [7:0]          cfg;
        logic [31:0]         rdata;
        aps_pkg::aps_pins_t  pin;
        aps_pkg::aps_pins_t  oe;
        logic                present;
        logic [7:0]          report;
    } aps_regs_t;

    aps_regs_t q;
    aps_regs_t d;
    logic      tmr_done;
    logic      gate_ok;
    logic      gpio_mode;

    // startup delay for address and select lines
    aps_startup_timer #(
        .CYCLES (STARTUP_CYCLES)
    ) u_timer (
        .clk    (clk),
        .nrst   (nrst),
        .done_q (tmr_done)
    );

    // pins may be active when bypass bit is set or bus power is seen
    assign gate_ok   = q.cfg[aps_pkg::CFG_GATE_BYPASS_BIT] | bus_detect_gate_in;
    assign gpio_mode = q.cfg[aps_pkg::CFG_GPIO_MODE_BIT];

    // next state, pin drive, presence and register port
    always_comb begin
        d       = q;
        d.rdata = '0;
        // state sequence; gated only once startup has ended
        case (q.st)
            aps_pkg::ST_WAIT: begin
                if (tmr_done) begin
                    d.st = gate_ok ? aps_pkg::ST_RUN : aps_pkg::ST_GATED;
                end
            end
            aps_pkg::ST_RUN: begin
                if (!gate_ok) begin
                    d.st = aps_pkg::ST_GATED;
                end
            end
            aps_pkg::ST_GATED: begin
                if (gate_ok) begin
                    d.st = aps_pkg::ST_RUN;
                end
            end
            default: begin
                d.st = aps_pkg::ST_WAIT;
            end
        endcase

        // pin values idle high unless the core owns the bus
        if (!gate_ok) begin
            // released so another controller can share the bus
            d.pin = aps_pkg::aps_pins_t'(aps_pkg::PINS_IDLE);
            d.oe  = aps_pkg::aps_pins_t'(aps_pkg::PINS_NONE);
        end else if (q.st == aps_pkg::ST_WAIT) begin
            // strobes held high at once, address and selects still off
            d.pin = aps_pkg::aps_pins_t'(aps_pkg::PINS_IDLE);
            d.oe  = aps_pkg::aps_pins_t'(aps_pkg::STROBE_MASK);
        end else begin
            // after the delay everything is driven from the core
            d.pin = core_pins;
            d.oe  = aps_pkg::aps_pins_t'(aps_pkg::PINS_IDLE);
        end

        // presence with selectable polarity, or a plain input
        if (gpio_mode) begin
            // presence function gone, so assume the drive is there
            d.present = 1'b1;
            d.report  = 8'h00;
            d.report[aps_pkg::REPORT_GPIO_BIT] = drive_present_in;
        end else begin
            d.present = drive_present_in ^ ~q.cfg[aps_pkg::CFG_PRES_POL_BIT];
            d.report  = 8'h00;
        end

        // register port; a write wins over nothing, reads answer next cycle
        if (reg_wr) begin
            if (reg_addr == aps_pkg::ADDR_CFG) begin
                d.cfg = reg_wdata[7:0];
            end
        end
        if (reg_rd) begin
            if (reg_addr == aps_pkg::ADDR_CFG) begin
                d.rdata = {24'h000000, q.cfg};
            end else if (reg_addr == aps_pkg::ADDR_STATUS) begin
                d.rdata[aps_pkg::ST_GPIO_BIT]    = gpio_mode;
                d.rdata[aps_pkg::ST_PRESENT_BIT] = q.present;
                d.rdata[aps_pkg::ST_GATE_OK_BIT] = gate_ok;
                d.rdata[aps_pkg::ST_DONE_BIT]    = tmr_done;
                d.rdata[aps_pkg::ST_STATE_LSB +: 2] = q.st;
            end else begin
                d.rdata = '0; // unmapped reads as zero
            end
        end
    end

    // register the record; strobes are driven high straight out of reset
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            q.st      <= aps_pkg::ST_WAIT;
            q.cfg     <= aps_pkg::CFG_RESET;
            q.rdata   <= '0;
            q.pin     <= aps_pkg::aps_pins_t'(aps_pkg::PINS_IDLE);
            q.oe      <= aps_pkg::aps_pins_t'(aps_pkg::STROBE_MASK);
            q.present <= 1'b0;
            q.report  <= 8'h00;
        end else begin
            q <= d;
        end
    end

    // outputs straight from flip-flops
    assign pin_o             = q.pin;
    assign pin_oe            = q.oe;
    assign reg_rdata         = q.rdata;
    assign drive_present_out = q.present;
    assign report_byte0      = q.report;
    assign startup_done      = tmr_done;

    // strobes are driven high while waiting and not gated
    a_strobe_startup_high: assert property (
        @(posedge clk) disable iff (!nrst)
        ($past(q.st) == aps_pkg::ST_WAIT) && $past(gate_ok) |->
            (pin_oe[7:5] == 3'b111) && (pin_o[7:5] == 3'b111)
    ) else $error("strobes not driven high during startup");

    // address lines stay off until the delay has run
    a_addr_held_off: assert property (
        @(posedge clk) disable iff (!nrst)
        !tmr_done |-> (pin_oe[4:2] == 3'b000)
    ) else $error("address driven before startup delay");

    // address lines driven once running
    a_addr_driven_run: assert property (
        @(posedge clk) disable iff (!nrst)
        ($past(q.st) == aps_pkg::ST_RUN) && $past(gate_ok) |->
            (pin_oe[4:2] == 3'b111) && (pin_o[4:2] == $past(core_pins[4:2]))
    ) else $error("address not driven after startup");

    // selects off before the delay, driven from the core two cycles after it
    a_select_after_delay: assert property (
        @(posedge clk) disable iff (!nrst)
        $rose(tmr_done) && q.cfg[aps_pkg::CFG_GATE_BYPASS_BIT] ##1
            q.cfg[aps_pkg::CFG_GATE_BYPASS_BIT] |->
            ##1 (pin_oe[1:0] == 2'b11)
    ) else $error("chip selects not driven after startup");

    // losing bus detect with bypass clear releases every pin
    a_gate_release: assert property (
        @(posedge clk) disable iff (!nrst)
        !q.cfg[aps_pkg::CFG_GATE_BYPASS_BIT] && !bus_detect_gate_in |->
            ##1 (pin_oe == aps_pkg::aps_pins_t'(aps_pkg::PINS_NONE))
    ) else $error("pins active while bus detect gates them");

    // gated pins float high impedance for bus sharing
    a_gated_hiz: assert property (
        @(posedge clk) disable iff (!nrst)
        (q.st == aps_pkg::ST_GATED) && !gate_ok |->
            ##1 (pin_oe == aps_pkg::aps_pins_t'(aps_pkg::PINS_NONE))
    ) else $error("gated pins not released");

    // polarity bit clear inverts the presence pin
    a_presence_pol: assert property (
        @(posedge clk) disable iff (!nrst)
        !gpio_mode && !q.cfg[aps_pkg::CFG_PRES_POL_BIT] |->
            ##1 (drive_present_out == !$past(drive_present_in))
    ) else $error("presence polarity wrong");

    // default active high presence follows the pin
    a_presence_default: assert property (
        @(posedge clk) disable iff (!nrst)
        !gpio_mode && q.cfg[aps_pkg::CFG_PRES_POL_BIT] |->
            ##1 (drive_present_out == $past(drive_present_in))
    ) else $error("presence does not follow pin");

    // general input mode reports the pin and drops presence function
    a_gpio_report: assert property (
        @(posedge clk) disable iff (!nrst)
        gpio_mode |->
            ##1 ((report_byte0[0] == $past(drive_present_in)) && drive_present_out &&
                (report_byte0[7:1] == 7'h00))
    ) else $error("general input not reported");

    // strobes never float while the pins are owned by this side
    a_strobe_never_float: assert property (
        @(posedge clk) disable iff (!nrst)
        gate_ok |-> ##1 (pin_oe[7:5] == 3'b111)
    ) else $error("strobes released while pins are owned");

    // leaving the wait state needs the startup delay to have run
    a_run_after_done: assert property (
        @(posedge clk) disable iff (!nrst)
        (q.st != aps_pkg::ST_WAIT) |-> tmr_done
    ) else $error("left startup wait before the delay ended");

    // the delay, once over, holds until the next reset
    a_done_holds: assert property (
        @(posedge clk) disable iff (!nrst)
        tmr_done |-> ##1 tmr_done
    ) else $error("startup delay restarted without reset");

    // selects stay released while the delay runs
    a_select_held_off: assert property (
        @(posedge clk) disable iff (!nrst)
        !tmr_done |-> (pin_oe[1:0] == 2'b00)
    ) else $error("chip selects driven before startup delay");

    // every released pin idles high behind its enable, so no glitch on re-enable
    for (genvar i = 0; i < 8; i++) begin : g_pin_chk
        a_pin_idle_high: assert property (
            @(posedge clk) disable iff (!nrst)
            !pin_oe[i] |-> pin_o[i]
        ) else $error("released pin not idling high");
    end

    // gated pins hold the idle level whatever the core asks
    a_gated_idle_high: assert property (
        @(posedge clk) disable iff (!nrst)
        !gate_ok |-> ##1 (pin_o == aps_pkg::aps_pins_t'(aps_pkg::PINS_IDLE))
    ) else $error("gated pins not idling high");

    // a running block drops to gated as soon as the gate closes
    a_run_to_gated: assert property (
        @(posedge clk) disable iff (!nrst)
        (q.st == aps_pkg::ST_RUN) && !gate_ok |-> ##1 (q.st == aps_pkg::ST_GATED)
    ) else $error("gate closed but state kept running");

    // the gated state reopens as soon as bus power returns
    a_gated_to_run: assert property (
        @(posedge clk) disable iff (!nrst)
        (q.st == aps_pkg::ST_GATED) && gate_ok |-> ##1 (q.st == aps_pkg::ST_RUN)
    ) else $error("gate open but state kept gated");

    // report byte stays clear while the pin means presence
    a_report_clear: assert property (
        @(posedge clk) disable iff (!nrst)
        !gpio_mode |-> ##1 (report_byte0 == 8'h00)
    ) else $error("report byte set outside general input mode");

    // read data stands for one cycle only, zero otherwise
    a_rdata_one_cycle: assert property (
        @(posedge clk) disable iff (!nrst)
        !reg_rd |-> ##1 (reg_rdata == 32'h00000000)
    ) else $error("read data outside its cycle");

    // a configuration write lands at the strobe edge
    a_cfg_write_lands: assert property (
        @(posedge clk) disable iff (!nrst)
        reg_wr && (reg_addr == aps_pkg::ADDR_CFG) |->
            ##1 (q.cfg == $past(reg_wdata[7:0]))
    ) else $error("configuration write lost");

    // status and unmapped writes leave the configuration alone
    a_cfg_write_only: assert property (
        @(posedge clk) disable iff (!nrst)
        !(reg_wr && (reg_addr == aps_pkg::ADDR_CFG)) |->
            ##1 (q.cfg == $past(q.cfg))
    ) else $error("configuration changed without a write");

    // status read carries state and gate level, upper bits clear
    a_status_read: assert property (
        @(posedge clk) disable iff (!nrst)
        reg_rd && (reg_addr == aps_pkg::ADDR_STATUS) |->
            ##1 ((reg_rdata[aps_pkg::ST_STATE_LSB +: 2] == $past(q.st)) &&
                (reg_rdata[aps_pkg::ST_GATE_OK_BIT] == $past(gate_ok)) &&
                ((reg_rdata >> (aps_pkg::ST_STATE_LSB + 2)) == 32'h00000000))
    ) else $error("status read does not match state");

endmodule // aps_pin_gate
`default_nettype wire

/* File: verilog/aps_pkg.sv */
// constants and carrier types shared by the ata pin startup and gating block
package aps_pkg;

    // clock and startup delay
    localparam int CLK_PERIOD_NS   = 100;
    localparam int STARTUP_TIME_MS = 2;
    localparam int STARTUP_TIME_US = STARTUP_TIME_MS * 1000;
    // least time, so round up to whole cycles
    localparam int STARTUP_CYCLES  = (STARTUP_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // register offsets on the plain register port
    localparam logic [7:0] ADDR_CFG    = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;

    // configuration byte field positions and reset value
    localparam int         CFG_PRES_POL_BIT    = 0;
    localparam int         CFG_GATE_BYPASS_BIT = 4;
    localparam int         CFG_GPIO_MODE_BIT   = 7;
    localparam logic [7:0] CFG_RESET           = 8'h11;

    // status register field positions
    localparam int ST_GPIO_BIT    = 0;
    localparam int ST_PRESENT_BIT = 1;
    localparam int ST_GATE_OK_BIT = 2;
    localparam int ST_DONE_BIT    = 3;
    localparam int ST_STATE_LSB   = 4;

    // report byte field position
    localparam int REPORT_GPIO_BIT = 0;

    // ata control pins carried together, all active low or idle high
    typedef struct packed {
        logic ata_write_strobe_n;
        logic ata_read_strobe_n;
        logic ata_dma_ack_n;
        logic ata_addr_bit2;
        logic ata_addr_bit1;
        logic ata_addr_bit0;
        logic ata_select_cmd_block_n;
        logic ata_select_ctrl_block_n;
    } aps_pins_t;

    localparam logic [7:0] PINS_IDLE   = 8'hff;
    localparam logic [7:0] PINS_NONE   = 8'h00;
    localparam logic [7:0] STROBE_MASK = 8'he0;

    // gray coded along wait -> run -> gated
    typedef enum logic [1:0] {
        ST_WAIT  = 2'b00,
        ST_RUN   = 2'b01,
        ST_GATED = 2'b11
    } aps_state_t;

endpackage

/* File: verilog/aps_startup_timer.sv */
// startup delay counter, raises a done level after a fixed cycle count
`timescale 1ns/1ps
`default_nettype none

module aps_startup_timer #(
    parameter int CYCLES = 20000
) (
    input  wire logic clk,
    input  wire logic nrst,
    output var  logic done_q
);

    localparam int W = $clog2(CYCLES + 1);
    localparam logic [W-1:0] LAST = W'(CYCLES - 1);

    logic [W-1:0] cnt_q;

    // counts once after reset, then holds done until the next reset
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cnt_q  <= '0;
            done_q <= 1'b0;
        end else if (!done_q) begin
            if (cnt_q == LAST) begin
                done_q <= 1'b1;
            end else begin
                cnt_q <= cnt_q + W'(1);
            end
        end
    end

endmodule // aps_startup_timer
`default_nettype wire

/* File: verification/aps_drive_model.sv */
// behavioural ata drive on the far side of the control pins
`timescale 1ns/1ps
`default_nettype none

module aps_drive_model (
    input  wire logic               clk,
    input  wire aps_pkg::aps_pins_t pin_o,
    input  wire aps_pkg::aps_pins_t pin_oe,
    input  wire logic               powered,
    output var  logic [7:0]         wire_lvl,
    output wire logic               drive_present_in
);
    aps_pkg::aps_pins_t last_q = '0;

    // remember what the bridge last drove on each line
    always_ff @(posedge clk) begin
        for (int i = 0; i < 8; i++) begin
            if (pin_oe[i]) begin
                last_q[i] <= pin_o[i];
            end
        end
    end

    // released lines show the inverse, so a stale drive never passes
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            wire_lvl[i] = pin_oe[i] ? pin_o[i] : ~last_q[i];
        end
    end

    // presence pin follows drive power
    assign drive_present_in = powered;
endmodule // aps_drive_model
`default_nettype wire

/* File: verification/ata_pin_startup_gating_tb.sv */
// self-checking bench for the ata pin startup and gating block
`timescale 1ns/1ps
`default_nettype none

module ata_pin_startup_gating_tb;
    localparam int STARTUP = 20;
    logic               clk;
    logic               nrst;
    logic [7:0]         reg_addr;
    logic [31:0]        reg_wdata;
    logic               reg_wr;
    logic               reg_rd;
    logic [31:0]        reg_rdata;
    aps_pkg::aps_pins_t core_pins;
    aps_pkg::aps_pins_t pin_o;
    aps_pkg::aps_pins_t pin_oe;
    logic               bus_detect_gate_in;
    logic               drive_present_in;
    logic               drive_present_out;
    logic [7:0]         report_byte0;
    logic               startup_done;
    logic               powered;
    logic [7:0]         wire_lvl;
    logic [31:0]        rd;
    int                 n_mismatch = 0;
    int                 cmp_count = 0;

    aps_pin_gate #(.STARTUP_CYCLES(STARTUP)) DUT (
        .clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .core_pins(core_pins),
        .pin_o(pin_o), .pin_oe(pin_oe), .bus_detect_gate_in(bus_detect_gate_in),
        .drive_present_in(drive_present_in), .drive_present_out(drive_present_out),
        .report_byte0(report_byte0), .startup_done(startup_done)
    );

    aps_drive_model drive (
        .clk(clk), .pin_o(pin_o), .pin_oe(pin_oe), .powered(powered),
        .wire_lvl(wire_lvl), .drive_present_in(drive_present_in)
    );

    // 10 mhz clock
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // let n edges pass, then sample settled outputs
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    // read data stands only in the cycle after the strobe
    task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // reset state, then the startup delay on address and selects
    task automatic t_startup();
        int n;
        n = 0;
        chk(32'(pin_oe), 32'he0);
        chk(32'(pin_o), 32'hff);
        @(posedge clk);
        nrst <= 1'b1;
        #1;
        while (startup_done !== 1'b1 && n < 100) begin
            chk(32'(pin_oe), 32'he0);
            cyc(1);
            n++;
        end
        if (n >= 100) begin
            n_mismatch++;
            wrap_up();
        end
        chk(32'(n), 32'(STARTUP));
        cyc(3);
        chk(32'(pin_oe), 32'hff);
        chk(32'(wire_lvl), 32'h5a);
        reg_read(aps_pkg::ADDR_CFG, rd);
        chk(rd, 32'h11);
        $display("test startup finished");
    endtask

    // bus-detect gating releases every pin, bypass bit overrides it
    task automatic t_gate();
        reg_write(aps_pkg::ADDR_CFG, 32'h01);
        bus_detect_gate_in <= 1'b0;
        cyc(3);
        chk(32'(pin_oe), 32'h00);
        chk(32'(pin_o), 32'hff);
        chk(32'(wire_lvl), 32'ha5);
        reg_read(aps_pkg::ADDR_STATUS, rd);
        chk(rd, 32'h3a);
        @(posedge clk);
        bus_detect_gate_in <= 1'b1;
        core_pins <= 8'ha5;
        cyc(3);
        chk(32'(pin_oe), 32'hff);
        chk(32'(wire_lvl), 32'ha5);
        reg_write(aps_pkg::ADDR_CFG, 32'h11);
        bus_detect_gate_in <= 1'b0;
        cyc(3);
        chk(32'(pin_oe), 32'hff);
        chk(32'(wire_lvl), 32'ha5);
        $display("test gate finished");
    endtask

    // presence polarity and general input mode, table of cfg, power, out, report
    task automatic t_presence();
        logic [11:0] tbl [6] = '{12'h116, 12'h110, 12'h104, 12'h102, 12'h917, 12'h912};
        foreach (tbl[i]) begin
            reg_write(aps_pkg::ADDR_CFG, {24'h0, tbl[i][11:4]});
            powered <= tbl[i][2];
            cyc(3);
            chk(32'(drive_present_out), 32'(tbl[i][1]));
            chk(32'(report_byte0), 32'(tbl[i][0]));
        end
        $display("test presence finished");
    endtask

    // read-only, unmapped and upper-bit accesses, one idle cycle apart
    task automatic t_regs();
        reg_write(aps_pkg::ADDR_CFG, 32'hffffff11);
        reg_write(aps_pkg::ADDR_STATUS, 32'h00000000);
        reg_read(aps_pkg::ADDR_CFG, rd);
        chk(rd, 32'h11);
        reg_read(aps_pkg::ADDR_STATUS, rd);
        chk(rd, 32'h1c);
        reg_read(8'h08, rd);
        chk(rd, 32'h0);
        cyc(1);
        chk(reg_rdata, 32'h0);
        $display("test regs finished");
    endtask

    // mid-run reset drives the strobes again and restores the configuration
    task automatic t_reset();
        reg_write(aps_pkg::ADDR_CFG, 32'h90);
        nrst <= 1'b0;
        cyc(2);
        chk(32'(pin_oe), 32'he0);
        chk(32'(pin_o), 32'hff);
        chk(32'(startup_done), 32'h0);
        chk(32'(drive_present_out), 32'h0);
        @(posedge clk);
        nrst <= 1'b1;
        cyc(STARTUP + 2);
        chk(32'(pin_oe), 32'hff);
        chk(32'(wire_lvl), 32'ha5);
        reg_read(aps_pkg::ADDR_CFG, rd);
        chk(rd, 32'h11);
        $display("test reset finished");
    endtask

    initial begin
        nrst = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 32'h0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        core_pins = 8'h5a;
        bus_detect_gate_in = 1'b1;
        powered = 1'b1;
        repeat (16) @(posedge clk);
        t_startup();
        t_gate();
        t_presence();
        t_regs();
        t_reset();
        wrap_up();
    end
endmodule // ata_pin_startup_gating_tb
`default_nettype wire
